// File: inc/irq_bank_map.svh
// register offsets, field positions, reset values and word codes of one
// interrupt bank; included by the bank logic, the bench and the checker
`ifndef IRQ_BANK_MAP_SVH
`define IRQ_BANK_MAP_SVH
// local i/o offsets (base decode is done outside)
`define OFS_CMD        4'h0
`define OFS_DATA       4'h1
`define OFS_W2_READ    4'h2
`define OFS_VEC_BASE   4'h8
// identifying bits of command words at the command offset
`define W1_ID_BIT      4
`define CW3_ID_BIT     3
// first init word fields
`define W1_LEVEL_BIT   3
`define W1_SINGLE_BIT  1
`define W1_NEED4_BIT   0
// fourth init word fields
`define W4_SFNM_BIT    4
`define W4_AUTOMATIC_END_OF_SERVICE_BIT    1
// eoi/rotate word fields
`define CW2_ROT_BIT    7
`define CW2_SL_BIT     6
`define CW2_EOI_BIT    5
// read/poll word fields
`define CW3_SPECIAL_MASK_ENABLE_BIT   6
`define CW3_SMM_BIT    5
`define CW3_POLL_BIT   2
`define CW3_RR_BIT     1
`define CW3_RIS_BIT    0
// reset values
`define LOWEST_RST     3'h7
`define BYTE_RST       8'h00
`define ALL_ONES       8'hff
`endif

// File: inc/irq_bank_pkg.sv
// types shared by the interrupt bank and whoever drives its i/o port
// assumes irq_bank_map.svh is on the include path
package irq_bank_pkg;
    // initialization sequence position
    typedef enum logic [2:0] {
        ST_UNINIT,
        ST_WAIT2,
        ST_WAIT3,
        ST_WAIT4,
        ST_RUN
    } init_state_e;
    // one i/o access, strobes are single-cycle
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } io_req_s;
endpackage

// File: logic/irq_bank.sv
// one eight-input interrupt bank: init word sequencing, control words,
// status/poll reads, mask read, and per-input vector registers.
// assumes a host that issues one-cycle rd/wr strobes on core_clk with the
// bank's base address already decoded into a local 4-bit offset.
`timescale 1ns/10ps
`include "irq_bank_map.svh"

module irq_bank #(
    parameter int N_IN = 8
) (
    input  wire logic                 core_clk,
    input  wire logic                 reset_n,
    input  wire irq_bank_pkg::io_req_s io_req,
    output logic [7:0]                io_rdata,
    input  wire logic [N_IN-1:0]      irq_pin_n,
    input  wire logic                 ack_pulse,
    output logic [7:0]                ack_vector,
    output logic                      int_out,
    output logic                      w2_request
);
    import irq_bank_pkg::*;

    init_state_e state_q;
    logic [N_IN-1:0] s1_q, s2_q, s3_q, lvl_q, prev_q;
    logic [N_IN-1:0] pend_q, insv_q, mask_q, slave_q;
    logic [7:0]      w2_q, rdata_q, ackv_q;
    logic [7:0]      vec_q [N_IN];
    logic [2:0]      lowest_q;
    logic            level_mode_q, single_q, need4_q;
    logic            automatic_end_of_service_q, sfnm_q, rot_automatic_end_of_service_q, smm_q;
    logic            read_isr_q, poll_q, w2_req_q, int_q;

    // decoded strobes
    logic wr_cmd, wr_data, rd_cmd, rd_data, rd_w2;
    logic is_w1, is_cw2, is_cw3;
    logic [7:0] wd;

    assign wd      = io_req.wdata;
    assign wr_cmd  = io_req.wr && io_req.addr == `OFS_CMD;
    assign wr_data = io_req.wr && io_req.addr == `OFS_DATA;
    assign rd_cmd  = io_req.rd && io_req.addr == `OFS_CMD;
    assign rd_data = io_req.rd && io_req.addr == `OFS_DATA;
    assign rd_w2   = io_req.rd && io_req.addr == `OFS_W2_READ;

    // words at the command offset are told apart by their id bits
    assign is_w1  = wr_cmd && wd[`W1_ID_BIT];
    assign is_cw2 = wr_cmd && !wd[`W1_ID_BIT] && !wd[`CW3_ID_BIT];
    assign is_cw3 = wr_cmd && !wd[`W1_ID_BIT] && wd[`CW3_ID_BIT];

    logic running;
    assign running = state_q == ST_RUN;

    // highest-priority set bit of v, given the lowest-priority level
    function automatic logic [3:0] top_of(input logic [7:0] v,
                                          input logic [2:0] low);
        logic [2:0] lv;
        top_of = 4'h0;
        lv = 3'h0;
        for (int k = 7; k >= 0; k--) begin
            lv = 3'(low + 3'(k) + 3'd1);
            if (v[lv]) begin
                top_of = {1'b1, lv};
            end
        end
    endfunction

    // rank 0 is the highest priority
    function automatic logic [2:0] rank_of(input logic [2:0] lv,
                                           input logic [2:0] low);
        rank_of = 3'(lv - low - 3'd1);
    endfunction

    // pin synchroniser: three stages, a change counts once 2 and 3 agree
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            s1_q <= '1;
            s2_q <= '1;
            s3_q <= '1;
        end else begin
            s1_q <= irq_pin_n;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // request level, inverted so that pending reads as one
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            lvl_q <= '0;
        end else begin
            for (int i = 0; i < N_IN; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    lvl_q[i] <= ~s3_q[i];
                end
            end
        end
    end

    // priority view of the current state
    logic [7:0] cand, block;
    logic [3:0] top_pend, top_insv;
    logic       want;

    always_comb begin
        cand  = pend_q & ~mask_q;
        block = insv_q;
        if (smm_q) begin
            // special mask: in-service levels only hold off themselves
            cand  = cand & ~insv_q;
            block = '0;
        end else if (sfnm_q && !single_q) begin
            // nested slaves may interrupt their own level again
            block = insv_q & ~(pend_q & slave_q);
        end
        top_pend = top_of(cand, lowest_q);
        top_insv = top_of(block, lowest_q);
        // fully nested compare by rank
        want = running && top_pend[3] && (!top_insv[3] ||
               rank_of(top_pend[2:0], lowest_q) <
               rank_of(top_insv[2:0], lowest_q));
    end

    // a poll read acknowledges like a hardware acknowledge
    logic poll_ack, any_ack;
    assign poll_ack = rd_cmd && poll_q;
    assign any_ack  = (ack_pulse || poll_ack) && want;

    // init sequence; word one restarts from anywhere
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            state_q <= ST_UNINIT;
        end else if (is_w1) begin
            state_q <= ST_WAIT2;
        end else if (wr_data) begin
            case (state_q)
                ST_WAIT2: begin
                    if (!single_q) begin
                        state_q <= ST_WAIT3;
                    end else if (need4_q) begin
                        state_q <= ST_WAIT4;
                    end else begin
                        state_q <= ST_RUN;
                    end
                end
                ST_WAIT3: begin
                    state_q <= need4_q ? ST_WAIT4 : ST_RUN;
                end
                ST_WAIT4: begin
                    state_q <= ST_RUN;
                end
                default: begin
                    state_q <= state_q;
                end
            endcase
        end
    end

    // word one mode bits
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            level_mode_q <= 1'b0;
            single_q     <= 1'b1;
            need4_q      <= 1'b0;
        end else if (is_w1) begin
            level_mode_q <= wd[`W1_LEVEL_BIT];
            single_q     <= wd[`W1_SINGLE_BIT];
            need4_q      <= wd[`W1_NEED4_BIT];
        end
    end

    // word two: stored for readback only, nothing reads it internally
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            w2_q <= `BYTE_RST;
        end else if (wr_data && state_q == ST_WAIT2) begin
            w2_q <= wd;
        end
    end

    // level 1.5 request: write sets, readback at the other offset clears;
    // a write in the same cycle as the read wins so no event is lost
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            w2_req_q <= 1'b0;
        end else if (wr_data && state_q == ST_WAIT2) begin
            w2_req_q <= 1'b1;
        end else if (rd_w2) begin
            w2_req_q <= 1'b0;
        end
    end

    // word three: slave map, only reached in cascade use
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            slave_q <= '0;
        end else if (is_w1) begin
            slave_q <= '0;
        end else if (wr_data && state_q == ST_WAIT3) begin
            slave_q <= wd;
        end
    end

    // word four options; no word four leaves auto end-of-service off
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            automatic_end_of_service_q <= 1'b0;
            sfnm_q <= 1'b0;
        end else if (is_w1) begin
            automatic_end_of_service_q <= 1'b0;
            sfnm_q <= 1'b0;
        end else if (wr_data && state_q == ST_WAIT4) begin
            automatic_end_of_service_q <= wd[`W4_AUTOMATIC_END_OF_SERVICE_BIT];
            sfnm_q <= wd[`W4_SFNM_BIT];
        end
    end

    // input mask
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            mask_q <= `BYTE_RST;
        end else if (is_w1) begin
            mask_q <= `BYTE_RST;
        end else if (wr_data && running) begin
            mask_q <= wd;
        end
    end

    // read/poll word: selection, poll flag and special mask
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            read_isr_q <= 1'b0;
            poll_q     <= 1'b0;
            smm_q      <= 1'b0;
        end else if (is_w1) begin
            read_isr_q <= 1'b0;
            poll_q     <= 1'b0;
            smm_q      <= 1'b0;
        end else if (is_cw3 && running) begin
            // poll overrides the register select for one read only
            poll_q <= wd[`CW3_POLL_BIT];
            if (wd[`CW3_RR_BIT]) begin
                read_isr_q <= wd[`CW3_RIS_BIT];
            end
            if (wd[`CW3_SPECIAL_MASK_ENABLE_BIT]) begin
                smm_q <= wd[`CW3_SMM_BIT];
            end
        end else if (rd_cmd) begin
            poll_q <= 1'b0;
        end
    end

    // edge detector history; word one forces "already active" so that
    // a fresh high-to-low edge is needed after init
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            prev_q <= `ALL_ONES;
        end else if (is_w1) begin
            prev_q <= `ALL_ONES;
        end else if (!poll_q) begin
            prev_q <= lvl_q;
        end
    end

    // pending bits; held still while a poll is outstanding
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            pend_q <= '0;
        end else if (is_w1) begin
            pend_q <= '0;
        end else begin
            for (int i = 0; i < N_IN; i++) begin
                if (any_ack && top_pend[2:0] == 3'(i)) begin
                    pend_q[i] <= level_mode_q && lvl_q[i];
                end else if (!poll_q) begin
                    if (level_mode_q) begin
                        pend_q[i] <= lvl_q[i];
                    end else if (lvl_q[i] && !prev_q[i]) begin
                        pend_q[i] <= 1'b1;
                    end else if (!lvl_q[i]) begin
                        pend_q[i] <= 1'b0;
                    end
                end
            end
        end
    end

    // eoi/rotate word decode
    logic       cw2_go, cw2_rot, cw2_sl, cw2_eoi;
    logic [2:0] cw2_lv, clr_lv;
    logic       clr_en;

    always_comb begin
        cw2_go  = is_cw2 && running;
        cw2_rot = wd[`CW2_ROT_BIT];
        cw2_sl  = wd[`CW2_SL_BIT];
        cw2_eoi = wd[`CW2_EOI_BIT];
        cw2_lv  = wd[2:0];
        // specific targets the field, non-specific the top of block, so none under special mask
        clr_en  = cw2_go && cw2_eoi && (cw2_sl || top_insv[3]);
        clr_lv  = cw2_sl ? cw2_lv : top_insv[2:0];
    end

    // in-service bits: acknowledge sets unless auto end-of-service
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            insv_q <= '0;
        end else if (is_w1) begin
            insv_q <= '0;
        end else begin
            for (int i = 0; i < N_IN; i++) begin
                if (any_ack && !automatic_end_of_service_q && top_pend[2:0] == 3'(i)) begin
                    insv_q[i] <= 1'b1;
                end else if (clr_en && clr_lv == 3'(i)) begin
                    insv_q[i] <= 1'b0;
                end
            end
        end
    end

    // rotation and priority setting
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            lowest_q   <= `LOWEST_RST;
            rot_automatic_end_of_service_q <= 1'b0;
        end else if (is_w1) begin
            lowest_q   <= `LOWEST_RST;
            rot_automatic_end_of_service_q <= 1'b0;
        end else if (cw2_go && !cw2_eoi && !cw2_sl) begin
            rot_automatic_end_of_service_q <= cw2_rot;
        end else if (cw2_go && cw2_rot && cw2_sl) begin
            lowest_q <= cw2_lv;
        end else if (cw2_go && cw2_rot && clr_en) begin
            lowest_q <= clr_lv;
        end else if (any_ack && automatic_end_of_service_q && rot_automatic_end_of_service_q) begin
            lowest_q <= top_pend[2:0];
        end
    end

    // vector registers, one per input
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            for (int i = 0; i < N_IN; i++) begin
                vec_q[i] <= `BYTE_RST;
            end
        end else if (io_req.wr && io_req.addr[3]) begin
            vec_q[io_req.addr[2:0]] <= wd;
        end
    end

    // vector handed out on acknowledge
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            ackv_q <= `BYTE_RST;
        end else if (ack_pulse && want) begin
            ackv_q <= vec_q[top_pend[2:0]];
        end
    end

    // read data, one cycle after the strobe
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            rdata_q <= `BYTE_RST;
        end else if (poll_ack || rd_cmd && poll_q) begin
            rdata_q <= {want, 4'h0, top_pend[2:0]};
        end else if (rd_cmd) begin
            rdata_q <= read_isr_q ? insv_q : pend_q;
        end else if (rd_data) begin
            rdata_q <= mask_q;
        end else if (rd_w2) begin
            rdata_q <= w2_q;
        end else if (io_req.rd && io_req.addr[3]) begin
            rdata_q <= vec_q[io_req.addr[2:0]];
        end else if (io_req.rd) begin
            rdata_q <= `BYTE_RST;
        end
    end

    // interrupt line to the processor
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            int_q <= 1'b0;
        end else begin
            int_q <= want;
        end
    end

    assign io_rdata   = rdata_q;
    assign ack_vector = ackv_q;
    assign int_out    = int_q;
    assign w2_request = w2_req_q;

endmodule

// File: testbench/host_io.sv
// host side of the bank's i/o port: one-cycle reads, writes and acknowledges
// assumes its tasks are called from one bench process only
`timescale 1ns/10ps

module host_io (
    input  wire logic             core_clk,
    output irq_bank_pkg::io_req_s io_req,
    output logic                  ack_pulse
);
    import irq_bank_pkg::*;

    // idle bus at time zero
    initial begin
        io_req = '0;
        ack_pulse = 1'b0;
    end

    // strobe for one cycle; released lines show inverted data so stale values never pass
    task automatic access(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(negedge core_clk);
        io_req <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge core_clk);
        io_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask

    // one acknowledge cycle
    task automatic ack();
        @(negedge core_clk);
        ack_pulse <= 1'b1;
        @(negedge core_clk);
        ack_pulse <= 1'b0;
    endtask
endmodule

// File: testbench/interrupt_bank_programming_bench.sv
// self-checking bench for one interrupt bank driven through its i/o port
// assumes the package, the bank, the host model and the checker are compiled first
`timescale 1ns/10ps
`include "irq_bank_map.svh"

module interrupt_bank_programming_bench;
    import irq_bank_pkg::*;
    logic       core_clk;
    logic       reset_n;
    io_req_s    io_req;
    logic [7:0] io_rdata;
    logic [7:0] irq_pin_n;
    logic       ack_pulse;
    logic [7:0] ack_vector;
    logic       int_out;
    logic       w2_request;
    logic [7:0] exp_q [$];
    logic [7:0] vec [8];
    logic [1:0] rd_p = 2'b00;
    logic [1:0] ak_p = 2'b00;
    int         fails = 0;
    int         comparisons = 0;
    int         cycles = 0;
    int         seed = 52;

    irq_bank #(.N_IN(8)) dut (.core_clk(core_clk), .reset_n(reset_n), .io_req(io_req),
        .io_rdata(io_rdata), .irq_pin_n(irq_pin_n), .ack_pulse(ack_pulse),
        .ack_vector(ack_vector), .int_out(int_out), .w2_request(w2_request));
    host_io host (.core_clk(core_clk), .io_req(io_req), .ack_pulse(ack_pulse));

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task automatic tally_and_finish();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        host.access(1'b1, a, d);
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        exp_q.push_back(exp);
        host.access(1'b0, a, 8'h00);
    endtask

    // full init; word two is read straight back so the level 1.5 request never lingers
    task automatic init(input logic [7:0] w1, input logic [7:0] w4);
        logic [7:0] w2;
        w2 = 8'($random(seed));
        wr(`OFS_CMD, w1);
        wr(`OFS_DATA, w2);
        chk("word two request", 8'h01, {7'h00, w2_request});
        rd(`OFS_W2_READ, w2);
        if (!w1[`W1_SINGLE_BIT]) wr(`OFS_DATA, 8'h0f);
        if (w1[`W1_NEED4_BIT]) wr(`OFS_DATA, w4);
    endtask

    // answers are judged a cycle after they are taken, and the timeout cuts a hang
    always @(posedge core_clk) begin
        rd_p <= {rd_p[0], io_req.rd};
        ak_p <= {ak_p[0], ack_pulse};
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fails++;
            tally_and_finish();
        end
    end

    always @(negedge core_clk) begin
        if (rd_p[1]) chk("read data", exp_q.pop_front(), io_rdata);
        if (ak_p[1]) chk("ack vector", exp_q.pop_front(), ack_vector);
    end

    initial begin
        reset_n = 1'b0;
        irq_pin_n = 8'hff;
        repeat (2) @(negedge core_clk);
        reset_n = 1'b1;
        chk("quiet outputs", 8'h00, {6'h00, int_out, w2_request});
        // abandoned cascade sequence, then single with word four
        wr(`OFS_CMD, 8'h11);
        wr(`OFS_DATA, 8'h3c);
        rd(`OFS_W2_READ, 8'h3c);
        init(8'h13, 8'h00);
        wr(`OFS_DATA, 8'h55);
        rd(`OFS_DATA, 8'h55);
        rd(`OFS_CMD, 8'h00);
        init(8'h11, 8'h00);
        rd(`OFS_DATA, 8'h00);
        wr(`OFS_DATA, 8'haa);
        rd(`OFS_DATA, 8'haa);
        wr(`OFS_DATA, 8'h00);
        rd(4'h3, 8'h00);
        for (int i = 0; i < 8; i++) begin
            vec[i] = 8'($random(seed));
            wr(`OFS_VEC_BASE + 4'(i), vec[i]);
        end
        for (int i = 0; i < 8; i++) rd(`OFS_VEC_BASE + 4'(i), vec[i]);
        $display("test registers done");
        // poll on a single request, then in-service reads and end of service
        irq_pin_n[3] = 1'b0;
        repeat (8) @(negedge core_clk);
        chk("int out", 8'h01, {7'h00, int_out});
        rd(`OFS_CMD, 8'h08);
        wr(`OFS_CMD, 8'h0c);
        rd(`OFS_CMD, 8'h83);
        wr(`OFS_CMD, 8'h0b);
        rd(`OFS_CMD, 8'h08);
        rd(`OFS_CMD, 8'h08);
        wr(`OFS_CMD, 8'h20);
        rd(`OFS_CMD, 8'h00);
        // poll and register read together: poll answers once, then in-service again
        irq_pin_n[5] = 1'b0;
        repeat (8) @(negedge core_clk);
        wr(`OFS_CMD, 8'h0f);
        rd(`OFS_CMD, 8'h85);
        rd(`OFS_CMD, 8'h20);
        wr(`OFS_CMD, 8'h20);
        $display("test poll done");
        // masked request stays silent; unmasked one is acknowledged with its vector
        irq_pin_n = 8'hff;
        wr(`OFS_DATA, 8'h40);
        irq_pin_n[6] = 1'b0;
        repeat (8) @(negedge core_clk);
        chk("masked int out", 8'h00, {7'h00, int_out});
        wr(`OFS_DATA, 8'h00);
        repeat (4) @(negedge core_clk);
        chk("int out", 8'h01, {7'h00, int_out});
        exp_q.push_back(vec[6]);
        host.ack();
        wr(`OFS_CMD, 8'h20);
        // a pin already low before word one must not count as a request
        irq_pin_n[7] = 1'b0;
        repeat (8) @(negedge core_clk);
        init(8'h12, 8'h00);
        rd(`OFS_CMD, 8'h00);
        rd(`OFS_DATA, 8'h00);
        repeat (4) @(negedge core_clk);
        $display("test interrupts done");
        // set priority moves the order; special mask lets a lower level past an in-service one
        irq_pin_n = 8'hff;
        wr(`OFS_CMD, 8'hc2);
        irq_pin_n[1] = 1'b0;
        irq_pin_n[4] = 1'b0;
        repeat (8) @(negedge core_clk);
        wr(`OFS_CMD, 8'h0c);
        rd(`OFS_CMD, 8'h84);
        repeat (2) @(negedge core_clk);
        chk("nested int out", 8'h00, {7'h00, int_out});
        wr(`OFS_CMD, 8'h68);
        repeat (2) @(negedge core_clk);
        chk("special mask int out", 8'h01, {7'h00, int_out});
        wr(`OFS_CMD, 8'h48);
        repeat (2) @(negedge core_clk);
        chk("normal mask int out", 8'h00, {7'h00, int_out});
        wr(`OFS_CMD, 8'h20);
        repeat (2) @(negedge core_clk);
        chk("after eoi int out", 8'h01, {7'h00, int_out});
        $display("test priority done");
        // level trigger with auto end of service, rotating on each acknowledge
        irq_pin_n = 8'hff;
        init(8'h1b, 8'h02);
        irq_pin_n[2] = 1'b0;
        irq_pin_n[3] = 1'b0;
        repeat (8) @(negedge core_clk);
        wr(`OFS_CMD, 8'h80);
        wr(`OFS_CMD, 8'h0c);
        rd(`OFS_CMD, 8'h82);
        wr(`OFS_CMD, 8'h0c);
        rd(`OFS_CMD, 8'h83);
        wr(`OFS_CMD, 8'h0b);
        rd(`OFS_CMD, 8'h00);
        wr(`OFS_CMD, 8'h0a);
        rd(`OFS_CMD, 8'h0c);
        // pending bits stay frozen from the poll word to its read
        wr(`OFS_CMD, 8'h0c);
        irq_pin_n = 8'hff;
        repeat (8) @(negedge core_clk);
        rd(`OFS_CMD, 8'h82);
        rd(`OFS_CMD, 8'h00);
        $display("test level done");
        tally_and_finish();
    end
endmodule

// File: testbench/irq_bank_chk.sv
// port-level assertions for one interrupt bank
// assumes irq_bank_pkg is compiled first and irq_bank_map.svh is on the include path
`timescale 1ns/10ps
`include "irq_bank_map.svh"

module irq_bank_chk #(
    parameter int N_IN = 8
) (
    input wire logic                  core_clk,
    input wire logic                  reset_n,
    input wire irq_bank_pkg::io_req_s io_req,
    input wire logic [7:0]            io_rdata,
    input wire logic [N_IN-1:0]       irq_pin_n,
    input wire logic                  ack_pulse,
    input wire logic [7:0]            ack_vector,
    input wire logic                  int_out,
    input wire logic                  w2_request
);
    import irq_bank_pkg::*;
    logic [7:0] wd_q;
    logic [7:0] w2_q;
    logic [7:0] rv_q;
    logic [7:0] vok_q;
    logic [7:0] vec_q [8];

    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    // shadow of the word two value, caught on the write that raised the request
    always_ff @(posedge core_clk) begin
        if (io_req.wr && io_req.addr == `OFS_DATA) wd_q <= io_req.wdata;
        if (w2_request && !$past(w2_request)) w2_q <= wd_q;
    end

    // vector shadow; only written entries are judged, reset contents are open
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            vok_q <= 8'h00;
        end else if (io_req.wr && io_req.addr[3]) begin
            vec_q[io_req.addr[2:0]] <= io_req.wdata;
            vok_q[io_req.addr[2:0]] <= 1'b1;
        end
        if (io_req.rd) rv_q <= vec_q[io_req.addr[2:0]];
    end

    a_reset_quiet: assert property (
        $rose(reset_n) |-> io_rdata == 8'h00 && ack_vector == 8'h00 && !int_out && !w2_request)
        else $error("outputs not quiet after reset");
    a_w2_clear: assert property (
        io_req.rd && io_req.addr == `OFS_W2_READ |=> !w2_request)
        else $error("word two request survived its readback");
    a_w2_hold: assert property (
        w2_request && !(io_req.rd && io_req.addr == `OFS_W2_READ) |=> w2_request)
        else $error("word two request dropped without readback");
    a_w2_readback: assert property (
        io_req.rd && io_req.addr == `OFS_W2_READ && w2_request |=> io_rdata == w2_q)
        else $error("word two readback differs from value written");
    a_rdata_hold: assert property (
        !io_req.rd |=> $stable(io_rdata))
        else $error("read data moved without a read");
    a_unmapped_zero: assert property (
        io_req.rd && io_req.addr inside {[4'h3:4'h7]} |=> io_rdata == 8'h00)
        else $error("unmapped offset read not zero");
    a_vec_readback: assert property (
        io_req.rd && io_req.addr[3] && vok_q[io_req.addr[2:0]] |=> io_rdata == rv_q)
        else $error("vector readback differs from value written");
    a_init_quiet: assert property (
        io_req.wr && io_req.addr == `OFS_CMD && io_req.wdata[`W1_ID_BIT] |-> ##2 !int_out)
        else $error("interrupt output active after init restart");
endmodule

bind irq_bank irq_bank_chk #(.N_IN(N_IN)) chk (
    .core_clk(core_clk), .reset_n(reset_n), .io_req(io_req), .io_rdata(io_rdata),
    .irq_pin_n(irq_pin_n), .ack_pulse(ack_pulse), .ack_vector(ack_vector),
    .int_out(int_out), .w2_request(w2_request));
